// file: cbreg_consts.vh
// register offsets, field positions and reset values of the output control bank
// assumes inclusion by bare name from the design files
`ifndef CBREG_CONSTS_VH
`define CBREG_CONSTS_VH
`define CBREG_ADDR_OUT_EN_HI 4'h2
`define CBREG_ADDR_PIN_RDBK 4'h3
`define CBREG_ADDR_SB_RDBK 4'h4
`define CBREG_ADDR_VEND_REV 4'h5
`define CBREG_ADDR_PART_ID 4'h6
`define CBREG_ADDR_BYTE_CNT 4'h7
`define CBREG_ADDR_SB_OVR_LO 4'h8
`define CBREG_RST_OUT_EN_HI 8'hff
`define CBREG_RST_PIN_RDBK 8'h00
`define CBREG_RST_SB_RDBK 1'h1
`define CBREG_RST_BYTE_CNT 6'h08
`define CBREG_RST_SB_OVR_LO 8'h00
`define CBREG_RST_OUT_GATE 8'h00
`define CBREG_RST_RDATA 8'h00
`define CBREG_BYTE_CNT_W 6
`define CBREG_REV_MSB 7
`define CBREG_REV_LSB 4
`define CBREG_VEND_MSB 3
`define CBREG_VEND_LSB 0
`endif

// file: cbreg_sync.v
// two-flop synchroniser for a bus of pin levels
// assumes pins are asynchronous to i_clk; reset value is a parameter
`timescale 1ns/1ps
module cbreg_sync #(
  parameter W = 8,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      meta_reg <= RST;
      sync_reg <= RST;
    end
    else
    begin
      meta_reg <= i_d;
      sync_reg <= meta_reg;
    end
  end
  assign o_q = sync_reg;
endmodule

// file: cbreg_top.v
// output control register bank: enables for outputs 8..15, pin readback, ids,
// block read byte count and first side-band override byte.
// assumes a byte-wide register port driven by the smbus engine on i_clk.
// Summary of operation
// RULE1: enable byte bits 7..0 gate clock outputs 15..8; 0 disables, 1 enables.
// RULE2: that enable byte sits at address 2 and resets to all ones.
// RULE3: address 3 reads live levels of enable pins 5..12, resets to zero.
// RULE4: pin status bit 7 is pin twelve down to bit 0 pin five.
// RULE5: address 4 bit 0 shows sideband mode pin, reset 1; upper bits zero.
// RULE6: address 5 returns revision in bits 7..4, maker code in bits 3..0.
// RULE7: address 6 returns the eight-bit part code directly.
// RULE8: address 7 bits 5..0 hold block read byte count, reset 8.
// RULE9: address 8 resets zero and forces outputs on in sideband mode.
// RULE10: override bits 7..0 map outputs 7..0; 1 keeps output enabled.
// RULE11: writes to read-only or reserved bits are ignored; reserved reads zero.
// RULE12: an output drives only with its enable bit set and its pin enable; in sideband mode the code uses the side-band enable in place of the pin.
`timescale 1ns/1ps
`include "cbreg_consts.vh"
module cbreg_top #(
  parameter [3:0] REV_CODE = 4'h1,
  parameter [3:0] MAKER_CODE = 4'h5,
  parameter [7:0] PART_CODE = 8'h3c
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire [3:0] i_addr,
  input wire i_wr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  input wire [7:0] i_enable_pin_n,
  input wire i_sideband_mode_select_pin,
  input wire [7:0] i_sideband_serial_interface_en,
  output wire [7:0] o_clk_out_en_hi,
  output wire [7:0] o_sideband_override_en,
  output wire [5:0] o_block_read_byte_count
);
  // MAKER_CODE, REV_CODE and PART_CODE defaults are arbitrary
  // byte count field width; bits above it are reserved
  localparam integer CNT_W = `CBREG_BYTE_CNT_W;
  // eight outputs in this bank
  localparam integer NUM_OUT = 8;
  reg [7:0] out_en_hi_reg;
  reg [7:0] out_en_hi_next;
  reg [CNT_W-1:0] byte_cnt_reg;
  reg [CNT_W-1:0] byte_cnt_next;
  reg [7:0] sb_ovr_lo_reg;
  reg [7:0] sb_ovr_lo_next;
  reg [7:0] rdata_next;
  reg [7:0] pin_state_reg;
  reg sb_state_reg;
  // registered gates keep the enable outputs glitch free across a register write
  reg [7:0] clk_en_hi_reg;
  reg [7:0] clk_en_hi_next;
  reg [7:0] ovr_en_reg;
  reg [7:0] ovr_en_next;
  reg [7:0] ident_byte;
  wire [7:0] pin_sync;
  wire sb_sync;
  wire wr_out_en_hi;
  wire wr_byte_cnt;
  wire wr_sb_ovr_lo;
  integer bit_idx;

  // enable pins are asynchronous: two flops before anything reads them
  cbreg_sync #(.W(8), .RST(`CBREG_RST_PIN_RDBK)) u_pin_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d(i_enable_pin_n),
    .o_q(pin_sync)
  );

  // the mode pin resets to sideband mode, matching the readback reset value
  cbreg_sync #(.W(1), .RST(`CBREG_RST_SB_RDBK)) u_sb_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d(i_sideband_mode_select_pin),
    .o_q(sb_sync)
  );

  // one address decoder shared by every write strobe
  function addr_hit;
    input [3:0] addr;
    input [3:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // gate one output: its register bit first, then the source that governs it
  function out_gate;
    input reg_bit;
    input sideband_mode;
    input sideband_en;
    input pin_level_n;
    begin
      if (!reg_bit)
        out_gate = 1'b0;
      else if (sideband_mode)
        out_gate = sideband_en;
      else
        out_gate = ~pin_level_n;
    end
  endfunction

  // writes to status, id and reserved bits decode to nothing and are dropped
  assign wr_out_en_hi = i_wr & addr_hit(i_addr, `CBREG_ADDR_OUT_EN_HI); // RULE1
  assign wr_byte_cnt = i_wr & addr_hit(i_addr, `CBREG_ADDR_BYTE_CNT); // RULE8
  assign wr_sb_ovr_lo = i_wr & addr_hit(i_addr, `CBREG_ADDR_SB_OVR_LO); // RULE9

  // identity byte built from field positions so the two codes cannot swap
  always @*
  begin
    ident_byte = 8'h00;
    ident_byte[`CBREG_REV_MSB:`CBREG_REV_LSB] = REV_CODE; // RULE6
    ident_byte[`CBREG_VEND_MSB:`CBREG_VEND_LSB] = MAKER_CODE; // RULE6
  end

  // next values of the writable fields; each holds unless its address is written
  always @*
  begin
    out_en_hi_next = out_en_hi_reg; // RULE11
    byte_cnt_next = byte_cnt_reg;
    sb_ovr_lo_next = sb_ovr_lo_reg;
    if (wr_out_en_hi)
    begin
      out_en_hi_next = i_wdata; // RULE1
    end
    if (wr_byte_cnt)
    begin
      // bits 7..6 of the byte are reserved, so the top two bits are cut on purpose
      byte_cnt_next = i_wdata[CNT_W-1:0]; // RULE8 RULE11
    end
    if (wr_sb_ovr_lo)
    begin
      sb_ovr_lo_next = i_wdata; // RULE9
    end
  end

  // pins 5..12 map onto outputs 8..15; in sideband mode the side-band enable
  // replaces the pin. the gate reads the synchronised status copy, so the
  // readback byte and the outputs never disagree about a pin.
  // the side-band enables come from logic on i_clk and need no synchroniser
  always @*
  begin
    clk_en_hi_next = 8'h00;
    for (bit_idx = 0; bit_idx < NUM_OUT; bit_idx = bit_idx + 1)
    begin
      clk_en_hi_next[bit_idx] = out_gate(out_en_hi_reg[bit_idx], sb_state_reg,
        i_sideband_serial_interface_en[bit_idx], pin_state_reg[bit_idx]); // RULE1 RULE12
    end
    // override bits only act in sideband mode; outside it they are only read back
    ovr_en_next = sb_ovr_lo_reg & {8{sb_state_reg}}; // RULE9 RULE10
  end

  // state registers; synchronous reset puts every field at its power-on value
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      out_en_hi_reg <= `CBREG_RST_OUT_EN_HI; // RULE2
      byte_cnt_reg <= `CBREG_RST_BYTE_CNT; // RULE8
      sb_ovr_lo_reg <= `CBREG_RST_SB_OVR_LO; // RULE9
      pin_state_reg <= `CBREG_RST_PIN_RDBK; // RULE3
      sb_state_reg <= `CBREG_RST_SB_RDBK; // RULE5
    end
    else
    begin
      out_en_hi_reg <= out_en_hi_next;
      byte_cnt_reg <= byte_cnt_next;
      sb_ovr_lo_reg <= sb_ovr_lo_next;
      pin_state_reg <= pin_sync; // RULE3 RULE4
      sb_state_reg <= sb_sync; // RULE5
    end
  end

  // outputs are held off during reset; the first gate follows one cycle later
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      clk_en_hi_reg <= `CBREG_RST_OUT_GATE;
      ovr_en_reg <= `CBREG_RST_OUT_GATE;
    end
    else
    begin
      clk_en_hi_reg <= clk_en_hi_next; // RULE12
      ovr_en_reg <= ovr_en_next; // RULE10
    end
  end

  // read mux; unmapped addresses and reserved bits read as zero
  always @*
  begin
    rdata_next = 8'h00;
    case (i_addr)
      `CBREG_ADDR_OUT_EN_HI: rdata_next = out_en_hi_reg; // RULE1
      `CBREG_ADDR_PIN_RDBK: rdata_next = pin_state_reg; // RULE4
      `CBREG_ADDR_SB_RDBK: rdata_next = {7'h00, sb_state_reg}; // RULE5 RULE11
      `CBREG_ADDR_VEND_REV: rdata_next = ident_byte; // RULE6
      `CBREG_ADDR_PART_ID: rdata_next = PART_CODE; // RULE7
      `CBREG_ADDR_BYTE_CNT: rdata_next = {2'h0, byte_cnt_reg}; // RULE11
      `CBREG_ADDR_SB_OVR_LO: rdata_next = sb_ovr_lo_reg;
      default: rdata_next = 8'h00; // RULE11
    endcase
  end

  // registered read data: one cycle after the address is presented
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= `CBREG_RST_RDATA;
    end
    else
    begin
      o_rdata <= rdata_next;
    end
  end

  // every output comes straight from a flop
  assign o_clk_out_en_hi = clk_en_hi_reg;
  assign o_sideband_override_en = ovr_en_reg;
  assign o_block_read_byte_count = byte_cnt_reg;
endmodule

// file: cbreg_props.sv
// checker on the register port
// bound into cbreg_top, one clock
`timescale 1ns/1ps
module cbreg_props(input i_clk,i_rst_n,i_wr,input [3:0] i_addr,input [7:0] i_wdata,o_rdata,i_enable_pin_n,
  input [5:0] o_block_read_byte_count);
  default clocking @(posedge i_clk); endclocking
  default disable iff(!i_rst_n);
  property p_wr;i_wr&&i_addr==4'h2 ##1 !i_wr&&i_addr==4'h2|=>o_rdata==$past(i_wdata,2);endproperty
  a_wr:assert property(p_wr) else $error("en");
  property p_cn;i_wr&&i_addr==4'h7|=>o_block_read_byte_count==$past(i_wdata[5:0]);endproperty
  a_cn:assert property(p_cn) else $error("cnt");
  property p_rc;i_addr==4'h7|=>o_rdata=={2'h0,$past(o_block_read_byte_count)};endproperty
  a_rc:assert property(p_rc) else $error("rc");
  property p_ro;i_wr&&i_addr!=4'h7|=>$stable(o_block_read_byte_count);endproperty
  a_ro:assert property(p_ro) else $error("ro");
  property p_id;i_wr&&i_addr==4'h6 ##1 i_addr==4'h6|=>$stable(o_rdata);endproperty
  a_id:assert property(p_id) else $error("id");
  property p_sb;i_addr==4'h4|=>o_rdata[7:1]==7'h00;endproperty
  a_sb:assert property(p_sb) else $error("sb");
  property p_un;i_addr>4'h8|=>o_rdata==8'h00;endproperty
  a_un:assert property(p_un) else $error("un");
  // pins pass three flops before the read register, so wait for four quiet edges
  property p_pn;$stable(i_enable_pin_n)[*4] ##0 i_addr==4'h3|=>o_rdata==$past(i_enable_pin_n);endproperty
  a_pn:assert property(p_pn) else $error("pin");
  cover property(i_wr&&i_addr==4'h2);
  cover property(i_wr&&i_addr==4'h8);
  cover property(i_addr==4'h3&&o_rdata!=8'h00);
endmodule
bind cbreg_top cbreg_props cbreg_props_inst(.*);

// file: cbreg_host.sv
// host model making register cycles on falling edges
// read data is taken one rising edge after the address
`timescale 1ns/1ps
module cbreg_host(input i_clk,input [7:0] o_rdata,output logic [3:0] i_addr=4'h0,output logic i_wr=1'h0,
  output logic [7:0] i_wdata=8'h00);
  task automatic wr(input [3:0] a,input [7:0] v);
    @(negedge i_clk) {i_addr,i_wdata,i_wr}={a,v,1'h1};
    // released data is inverted so a stale byte never looks valid
    @(negedge i_clk) {i_wdata,i_wr}={~v,1'h0};
  endtask
  task automatic rd(input [3:0] a,output [7:0] v);
    @(negedge i_clk) i_addr=a;
    @(negedge i_clk) v=o_rdata;
  endtask
endmodule

// file: cbreg_top_tb.sv
// bench for the output control bank
// the host model makes every register cycle
`timescale 1ns/1ps
`define CHK(a,e) begin checks_done++; if((a)!==(e)) begin n_mismatch++; $display("MISMATCH %0t %h %h",$time,a,e); end end
module cbreg_top_tb;
  logic i_clk=1'h0,i_rst_n=1'h0,i_wr,i_sideband_mode_select_pin=1'h0;
  logic [3:0] i_addr;
  logic [5:0] o_block_read_byte_count;
  logic [7:0] i_wdata,o_rdata,i_enable_pin_n=8'h00,i_sideband_serial_interface_en=8'hff,o_clk_out_en_hi,
    o_sideband_override_en,d;
  int n_mismatch=0,checks_done=0;
  always #12.5 i_clk=~i_clk;
  cbreg_host cbreg_host_inst(.*);
  cbreg_top cbreg_top_inst(.*);
  task automatic complete_run;
    $display("checks %0d mismatches %0d",checks_done,n_mismatch);
    if(n_mismatch==0&&checks_done>0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // reads addresses 2 to 9 and compares each against one byte of e
  task automatic sweep(input [63:0] e);
    for(int a=0;a<8;a++)
    begin
      cbreg_host_inst.rd(4'(a+2),d);
      `CHK(d,e[63-8*a-:8])
    end
  endtask
  initial begin #20000; n_mismatch++; complete_run; end
  initial
  begin
    repeat(10) @(negedge i_clk);
    i_rst_n=1'h1;
    repeat(4) @(negedge i_clk);
    sweep(64'hff0000153c080000);
    for(int a=2;a<10;a++) cbreg_host_inst.wr(4'(a),8'hc3);
    sweep(64'hc30000153c03c300);
    `CHK({o_clk_out_en_hi,o_sideband_override_en,o_block_read_byte_count},22'h30c003)
    {i_enable_pin_n,i_sideband_mode_select_pin,i_sideband_serial_interface_en}={8'h81,1'h1,8'h0f};
    repeat(4) @(negedge i_clk);
    sweep(64'hc38101153c03c300);
    `CHK({o_clk_out_en_hi,o_sideband_override_en},16'h03c3)
    complete_run;
  end
endmodule
